// ---- hdl/mic_defines.svh ----
// constants of the maskable interrupt priority controller
// assumes: included by the package and the controller module only
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

`define MIC_NSRC          12
`define MIC_LVL0          2'h0
`define MIC_LVL1          2'h1
`define MIC_LVL2          2'h2

// word index of each register, byte address is four times it
`define MIC_IDX_REQ       3'h0
`define MIC_IDX_EN        3'h1
`define MIC_IDX_PLO       3'h2
`define MIC_IDX_PHI       3'h3
`define MIC_IDX_CTRL      3'h4
`define MIC_IDX_STAT      3'h5

// control word fields
`define MIC_CTRL_MEN      0
`define MIC_CTRL_PUSE     1
`define MIC_CTRL_XP       2
`define MIC_RST_CTRL      3'h0
`define MIC_RST_SRC       12'h000

// entry counter start values, one below the cycle count; the second with the code segment saved
`define MIC_ENTRY_LAST    5'h0d
`define MIC_ENTRY_LAST_XP 5'h10

// vectors in source order; source index rises with vector address
`define MIC_VEC_TABLE {16'h0070, 16'h006e, 16'h0038, 16'h0032, 16'h0030, 16'h002c, \
	16'h002a, 16'h0028, 16'h0022, 16'h0020, 16'h000e, 16'h000a}

`endif

// ---- hdl/mic_pkg.sv ----
// types of the maskable interrupt priority controller
// assumes: mic_defines.svh is on the include path
`include "mic_defines.svh"

package mic_pkg;

	typedef enum logic [1:0] {
		MIC_IDLE  = 2'b01,
		MIC_ENTRY = 2'b10
	} mic_fsm_t;

	// peripheral event strobes, one cycle each, same clock
	typedef struct packed {
		logic timer1_ovf;
		logic rt_evt_a;
		logic rt_evt_b;
		logic serial_rdy;
		logic serial_tmr_ovf;
		logic gp_tmr_ovf;
		logic adc_done;
		logic pwc_underflow;
		logic pwc_match;
	} mic_evt_t;

	typedef struct packed {
		mic_fsm_t              fsm;
		logic [4:0]            cnt;
		logic                  xp;
		logic                  cseg;
		logic                  take;
		logic [15:0]           vec;
		logic [3:0]            last_src;
		logic [2:0]            lvl_busy;
		logic [`MIC_NSRC-1:0]  req;
		logic [`MIC_NSRC-1:0]  en;
		logic [`MIC_NSRC-1:0]  plo;
		logic [`MIC_NSRC-1:0]  phi;
		logic [2:0]            ctrl;
		logic                  ack;
		logic [31:0]           dat;
		logic [3:0]            pin_s1;
		logic [3:0]            pin_s2;
		logic [3:0]            pin_s3;
	} mic_state_t;

endpackage : mic_pkg

// ---- hdl/mic_ctrl.sv ----
// maskable interrupt priority controller with a classic wishbone slave
// assumes: cpu core runs on mclk_i, sequences entry from irq_take_o and
// pulses ret_i once per return_from_interrupt; external pins are async
//
// Overview of operation
// - source event sets bit, acceptance clears it
// - software may write request bits either way
// - per-source enable blocks or permits its interrupt
// - master enable zero blocks every maskable interrupt
// - only requested and doubly enabled sources compete
// - priority-use off means no check against levels in progress
// - two priority bits give levels 0, 1, 2
// - nothing in progress means immediate generation
// - need strictly higher level; nmi holds all
// - highest level wins, then lowest vector
// - accept clears request, master enable; pushes level
// - entry takes fourteen cycles, seventeen when expanded
// - return pops top level, sets master enable
// - expanded mode also saves code segment register
// - each source owns a fixed vector
// - counter underflow and match share one bit
`timescale 1ns/100ps
`include "mic_defines.svh"

module mic_ctrl
	import mic_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire mic_evt_t    evt_i,
	input  wire logic        ext_pin_irq_0_i,
	input  wire logic        ext_pin_irq_1_i,
	input  wire logic        ext_pin_irq_2_i,
	input  wire logic        ext_pin_irq_3_i,
	input  wire logic        nmi_busy_i,
	input  wire logic        ret_i,
	output logic             irq_take_o,
	output logic      [15:0] vec_o,
	output logic             entry_busy_o,
	output logic      [4:0]  entry_cnt_o,
	output logic             cseg_save_o,
	output logic             master_en_o,
	output logic             prio_use_o,
	output logic      [2:0]  lvl_busy_o
);

	localparam logic [`MIC_NSRC*16-1:0] VEC_TABLE = `MIC_VEC_TABLE;

	mic_state_t s_r;
	mic_state_t s_nxt;

	// level of one source from its two priority bits
	function automatic logic [1:0] src_level(input logic hi, input logic lo);
		logic [1:0] l;
		l = `MIC_LVL0;
		if (hi)
			l = `MIC_LVL2;
		else if (lo)
			l = `MIC_LVL1;
		return l;
	endfunction

	// byte-lane merge for a twelve-bit register in the low lanes
	function automatic logic [`MIC_NSRC-1:0] lane_merge(
		input logic [`MIC_NSRC-1:0] old_v,
		input logic [31:0]          wr_v,
		input logic [3:0]           sel
	);
		logic [`MIC_NSRC-1:0] m;
		m = old_v;
		if (sel[0])
			m[7:0] = wr_v[7:0];
		if (sel[1])
			m[`MIC_NSRC-1:8] = wr_v[`MIC_NSRC-1:8];
		return m;
	endfunction

	logic [`MIC_NSRC-1:0] hw_set;
	logic [`MIC_NSRC-1:0] pend;
	logic [3:0]           pin_rise;
	logic [1:0]           best_lvl;
	logic [3:0]           best_idx;
	logic                 best_ok;
	logic [1:0]           lvl;
	logic                 lvl_ok;
	logic                 bus_req;
	logic                 do_ret;
	logic [2:0]           idx;

	always_comb begin
		s_nxt = s_r;
		s_nxt.take = 1'b0;
		s_nxt.ack = 1'b0;
		best_lvl = `MIC_LVL0;
		best_idx = 4'h0;
		best_ok = 1'b0;
		lvl = `MIC_LVL0;
		lvl_ok = 1'b0;
		idx = wb_adr_i[4:2];

		// pins pass two flops; the third only feeds edge detection
		s_nxt.pin_s1 = {ext_pin_irq_3_i, ext_pin_irq_2_i, ext_pin_irq_1_i, ext_pin_irq_0_i};
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_s3 = s_r.pin_s2;
		pin_rise = s_r.pin_s2 & ~s_r.pin_s3;

		hw_set = {pin_rise[3], pin_rise[2], pin_rise[1],
			evt_i.pwc_underflow | evt_i.pwc_match,
			evt_i.adc_done, evt_i.gp_tmr_ovf, evt_i.serial_tmr_ovf, evt_i.serial_rdy,
			evt_i.rt_evt_b, evt_i.rt_evt_a, evt_i.timer1_ovf, pin_rise[0]};

		pend = s_r.req & s_r.en & {`MIC_NSRC{s_r.ctrl[`MIC_CTRL_MEN]}};

		// ascending scan: a later source only wins on a strictly higher level
		for (int i = 0; i < `MIC_NSRC; i++) begin
			lvl = src_level(s_r.phi[i], s_r.plo[i]);
			if (!s_r.ctrl[`MIC_CTRL_PUSE])
				lvl_ok = 1'b1;
			else
				lvl_ok = ~|(s_r.lvl_busy >> lvl);
			if (pend[i] && lvl_ok && (!best_ok || lvl > best_lvl)) begin
				best_ok = 1'b1;
				best_lvl = lvl;
				best_idx = 4'(i);
			end
		end
		if (nmi_busy_i)
			best_ok = 1'b0;

		// register bus, one wait state, ack dropped after one cycle
		bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
		if (bus_req) begin
			s_nxt.ack = 1'b1;
			s_nxt.dat = 32'h0;
			if (wb_we_i) begin
				unique case (idx)
					`MIC_IDX_REQ:  s_nxt.req = lane_merge(s_r.req, wb_dat_i, wb_sel_i);
					`MIC_IDX_EN:   s_nxt.en = lane_merge(s_r.en, wb_dat_i, wb_sel_i);
					`MIC_IDX_PLO:  s_nxt.plo = lane_merge(s_r.plo, wb_dat_i, wb_sel_i);
					`MIC_IDX_PHI:  s_nxt.phi = lane_merge(s_r.phi, wb_dat_i, wb_sel_i);
					`MIC_IDX_CTRL: begin
						if (wb_sel_i[0])
							s_nxt.ctrl = wb_dat_i[2:0];
					end
					default: ;
				endcase
			end else begin
				unique case (idx)
					`MIC_IDX_REQ:  s_nxt.dat[`MIC_NSRC-1:0] = s_r.req;
					`MIC_IDX_EN:   s_nxt.dat[`MIC_NSRC-1:0] = s_r.en;
					`MIC_IDX_PLO:  s_nxt.dat[`MIC_NSRC-1:0] = s_r.plo;
					`MIC_IDX_PHI:  s_nxt.dat[`MIC_NSRC-1:0] = s_r.phi;
					`MIC_IDX_CTRL: s_nxt.dat[2:0] = s_r.ctrl;
					`MIC_IDX_STAT: s_nxt.dat[15:0] = {s_r.last_src, 2'h0, s_r.fsm[1],
						1'b0, s_r.lvl_busy, s_r.cnt};
					default: ;
				endcase
			end
		end

		// return wins over acceptance in the same idle cycle
		do_ret = ret_i && s_r.fsm == MIC_IDLE;
		unique case (s_r.fsm)
			MIC_IDLE: begin
				if (do_ret) begin
					if (s_r.lvl_busy[2])
						s_nxt.lvl_busy[2] = 1'b0;
					else if (s_r.lvl_busy[1])
						s_nxt.lvl_busy[1] = 1'b0;
					else
						s_nxt.lvl_busy[0] = 1'b0;
					s_nxt.ctrl[`MIC_CTRL_MEN] = 1'b1;
				end else if (best_ok) begin
					s_nxt.req[best_idx] = 1'b0;
					s_nxt.ctrl[`MIC_CTRL_MEN] = 1'b0;
					s_nxt.lvl_busy[best_lvl] = 1'b1;
					s_nxt.vec = VEC_TABLE[best_idx*16 +: 16];
					s_nxt.last_src = best_idx;
					s_nxt.take = 1'b1;
					s_nxt.xp = s_r.ctrl[`MIC_CTRL_XP];
					s_nxt.fsm = MIC_ENTRY;
					s_nxt.cnt = s_r.ctrl[`MIC_CTRL_XP] ? `MIC_ENTRY_LAST_XP : `MIC_ENTRY_LAST;
				end
			end
			MIC_ENTRY: begin
				if (s_r.cnt == 5'h0)
					s_nxt.fsm = MIC_IDLE;
				else
					s_nxt.cnt = s_r.cnt - 5'h1;
			end
			default: s_nxt.fsm = MIC_IDLE;
		endcase

		s_nxt.cseg = s_nxt.fsm == MIC_ENTRY && s_nxt.xp && s_nxt.cnt > `MIC_ENTRY_LAST;

		s_nxt.req = s_nxt.req | hw_set;
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r.fsm <= MIC_IDLE;
			s_r.cnt <= 5'h0;
			s_r.xp <= 1'b0;
			s_r.cseg <= 1'b0;
			s_r.take <= 1'b0;
			s_r.vec <= 16'h0;
			s_r.last_src <= 4'h0;
			s_r.lvl_busy <= 3'h0;
			s_r.req <= `MIC_RST_SRC;
			s_r.en <= `MIC_RST_SRC;
			s_r.plo <= `MIC_RST_SRC;
			s_r.phi <= `MIC_RST_SRC;
			s_r.ctrl <= `MIC_RST_CTRL;
			s_r.ack <= 1'b0;
			s_r.dat <= 32'h0;
			s_r.pin_s1 <= 4'h0;
			s_r.pin_s2 <= 4'h0;
			s_r.pin_s3 <= 4'h0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign irq_take_o = s_r.take;
	assign vec_o = s_r.vec;
	assign entry_busy_o = s_r.fsm[1];
	assign entry_cnt_o = s_r.cnt;
	assign cseg_save_o = s_r.cseg;
	assign master_en_o = s_r.ctrl[`MIC_CTRL_MEN];
	assign prio_use_o = s_r.ctrl[`MIC_CTRL_PUSE];
	assign lvl_busy_o = s_r.lvl_busy;

endmodule // mic_ctrl

// ---- sim/mic_ctrl_asserts.sv ----
// port assertions for mic_ctrl
// assumes: one clock domain, bound to every mic_ctrl instance
`timescale 1ns/100ps
module mic_ctrl_chk (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       ce_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       nmi_busy_i,
	input wire logic       ret_i,
	input wire logic       irq_take_o,
	input wire logic       entry_busy_o,
	input wire logic [4:0] entry_cnt_o,
	input wire logic       cseg_save_o,
	input wire logic       master_en_o,
	input wire logic       prio_use_o,
	input wire logic [2:0] lvl_busy_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_start;
		irq_take_o && entry_busy_o;
	endsequence
	AST_WB_ACK: assert property (s_req |=> s_ack)
		else $error("bus answer late");
	AST_ENTRY_LOAD: assert property (s_start |-> entry_cnt_o == (cseg_save_o ? 5'h10 : 5'h0d))
		else $error("entry length wrong");
	AST_CNT_STEP: assert property (entry_busy_o && entry_cnt_o != 5'h0 && ce_i |=>
		entry_busy_o && entry_cnt_o == $past(entry_cnt_o) - 5'h1)
		else $error("entry count skipped");
	AST_ENTRY_END: assert property (entry_busy_o && entry_cnt_o == 5'h0 && ce_i |=> !entry_busy_o)
		else $error("entry too long");
	AST_TAKE_MEN: assert property (s_start |-> !master_en_o)
		else $error("master enable kept");
	AST_MEN_GATE: assert property (!master_en_o && ce_i |=> !irq_take_o)
		else $error("take while masked");
	AST_NMI_HOLD: assert property (nmi_busy_i && ce_i |=> !irq_take_o)
		else $error("take during nmi");
	AST_TOP_HOLD: assert property (prio_use_o && lvl_busy_o[2] && ce_i |=> !irq_take_o)
		else $error("take above top level");
	AST_RET_MEN: assert property (ret_i && !entry_busy_o && ce_i |=> master_en_o)
		else $error("return left mask");
endmodule // mic_ctrl_chk

bind mic_ctrl mic_ctrl_chk u_chk (.mclk_i, .nrst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.nmi_busy_i, .ret_i, .irq_take_o, .entry_busy_o, .entry_cnt_o, .cseg_save_o,
	.master_en_o, .prio_use_o, .lvl_busy_o);

// ---- sim/mic_cpu_model.sv ----
// cpu core side: counts routines entered, returns on request
// assumes: controller clock, ret_req_i pulsed by the bench
`timescale 1ns/100ps
module mic_cpu_model (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic take_i,
	input  wire logic busy_i,
	input  wire logic ret_req_i,
	output logic      ret_o
);
	logic [3:0] depth_r;
	// no return mid-entry: the core is still saving context then
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			depth_r <= 4'h0;
			ret_o <= 1'b0;
		end else begin
			ret_o <= ret_req_i && !busy_i && !ret_o && depth_r != 4'h0;
			depth_r <= depth_r + {3'h0, take_i} - {3'h0, ret_o};
		end
	end
endmodule // mic_cpu_model

// ---- sim/mic_ctrl_tb_top.sv ----
// bench for mic_ctrl: wishbone calls, events, cpu model returns
// assumes: checker bound from its own file
`timescale 1ns/100ps
module mic_ctrl_tb_top;
	import mic_pkg::*;
	logic mclk_i = 1'b0, nrst_i = 1'b0, cs = 1'b0, we = 1'b0, pin0 = 1'b0, nmi = 1'b0;
	logic rreq = 1'b0;
	logic [4:0] adr = 5'h0;
	logic [31:0] wd = 32'h0, rv;
	mic_evt_t evt = '0;
	wire logic ack, take, busy, cseg, men, puse, ret;
	wire logic [31:0] dato;
	wire logic [15:0] vec;
	wire logic [4:0] cnt;
	wire logic [2:0] lvl;
	int err_count, num_checks, bcy, tkn;
	logic [15:0] tvec;
	mic_ctrl dut (.mclk_i, .nrst_i, .ce_i(1'b1), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack),
		.evt_i(evt), .ext_pin_irq_0_i(pin0), .ext_pin_irq_1_i(1'b0), .ext_pin_irq_2_i(1'b0),
		.ext_pin_irq_3_i(1'b0), .nmi_busy_i(nmi), .ret_i(ret), .irq_take_o(take),
		.vec_o(vec), .entry_busy_o(busy), .entry_cnt_o(cnt), .cseg_save_o(cseg),
		.master_en_o(men), .prio_use_o(puse), .lvl_busy_o(lvl));
	mic_cpu_model cpu (.mclk_i, .nrst_i, .take_i(take), .busy_i(busy), .ret_req_i(rreq),
		.ret_o(ret));
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	// take can fall inside a bus call, so record it here rather than poll for it
	always @(posedge mclk_i) begin
		if (take === 1'b1) begin
			tkn++;
			tvec = vec;
			bcy = 1;
		end else if (busy === 1'b1) begin
			bcy++;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic lim(input int n);
		if (n >= 60) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cs <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack !== 1'b1 && n < 60);
		lim(n);
		rv = dato;
		cs <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk("register", e, rv);
	endtask
	task automatic wtk(input logic [15:0] v);
		int n;
		n = 0;
		while (tkn == 0 && n < 60) begin
			@(posedge mclk_i);
			n++;
		end
		lim(n);
		tkn--;
		chk("vector", {16'h0, v}, {16'h0, tvec});
		repeat (25) @(posedge mclk_i);
		chk("takes", 32'h0, tkn);
	endtask
	task automatic rt();
		rreq <= 1'b1;
		@(posedge mclk_i);
		rreq <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
		acc(1'b1, 5'h00, 32'hfff);
		rd(5'h00, 32'hfff);
		evt.pwc_match <= 1'b1;
		fork
			acc(1'b1, 5'h00, 32'h0);
			begin
				@(posedge mclk_i);
				evt <= '0;
			end
		join
		rd(5'h00, 32'h100);
		acc(1'b1, 5'h00, 32'h0);
		evt.pwc_underflow <= 1'b1;
		@(posedge mclk_i);
		evt <= '0;
		pin0 <= 1'b1;
		repeat (6) @(posedge mclk_i);
		rd(5'h00, 32'h101);
		acc(1'b1, 5'h10, 32'h1);
		rd(5'h14, 32'h0);
		acc(1'b1, 5'h04, 32'hfff);
		wtk(16'h000a);
		chk("cycles", 32'h0e, bcy);
		rd(5'h00, 32'h100);
		rd(5'h10, 32'h0);
		acc(1'b1, 5'h10, 32'h3);
		rd(5'h14, 32'h20);
		acc(1'b1, 5'h08, 32'h100);
		wtk(16'h0032);
		rd(5'h14, 32'h8060);
		rt();
		rd(5'h14, 32'h8020);
		rd(5'h10, 32'h3);
		rt();
		acc(1'b1, 5'h0c, 32'h200);
		acc(1'b1, 5'h00, 32'h202);
		wtk(16'h0038);
		nmi <= 1'b1;
		rt();
		rd(5'h14, 32'h9000);
		nmi <= 1'b0;
		wtk(16'h000e);
		acc(1'b1, 5'h10, 32'h5);
		acc(1'b1, 5'h00, 32'h800);
		wtk(16'h0070);
		chk("cycles", 32'h11, bcy);
		summarize();
	end
endmodule // mic_ctrl_tb_top
